// ==== shared/ifc_pkg.sv ====
// Shared constants and types for the in-band flow-control and status link
package ifc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int CAL_ENTRIES = 256; // Calendar length
    localparam int CAL_GROUP = 16; // Entries per control word
    localparam int CAL_GROUPS = CAL_ENTRIES / CAL_GROUP;
    localparam int LANES = 12; // Receive lanes
    localparam int WORD_W = 64; // Link word width
    localparam int BURST_W = 8; // Width of min burst length
    localparam int GRP_W = $clog2(CAL_GROUPS);

    // ****************************************
    // Field positions in link words
    // ****************************************
    localparam int CW_CAL_HI = 55; // Calendar field top bit
    localparam int CW_CAL_LO = 40; // Calendar field low bit
    localparam int CW_CAL_START = 56; // First-group marker
    localparam int DW_LANE_STAT = 33; // Diagnostic lane status
    localparam int DW_INTF_STAT = 32; // Diagnostic interface status

    // ****************************************
    // Values
    // ****************************************
    localparam logic XON = 1'b1; // Calendar bit meaning go
    localparam logic XOFF = 1'b0; // Calendar bit meaning stop
    localparam logic [GRP_W-1:0] GRP_FIRST = 4'h0;
    localparam logic [BURST_W-1:0] BURST_ZERO = 8'h00;
    localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
    localparam logic [BURST_W-1:0] BURST_MAX = 8'hFF;
    localparam logic [BURST_W-1:0] MIN_BURST_RST = 8'h02; // Default min burst
    localparam logic [WORD_W-1:0] WORD_ZERO = 64'h0000_0000_0000_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100; // ref_clk period
    localparam int TX_RST_NS = 800; // Least transmit reset pulse
    localparam int TX_RST_CYC = (TX_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TX_RST_CYC_W = 4'(TX_RST_CYC);

    // Host recovery sequencer
    typedef enum logic [1:0] {IFC_RUN, IFC_RESET, IFC_WAIT} ifc_rec_t;
endpackage : ifc_pkg

// ==== shared/ifc_link_if.sv ====
// Interface joining the framer end and the user logic end
`timescale 1ns/1ps
`default_nettype none
interface ifc_link_if;
    import ifc_pkg::*;
    // ****************************************
    // User to framer
    // ****************************************
    logic [CAL_ENTRIES-1:0] tx_calendar_xon_bits; // 1 XON, 0 XOFF per entry
    logic [BURST_W-1:0] tx_min_burst_length; // Least data words per burst
    logic tx_word_valid; // Word offered
    logic tx_word_ctrl; // Word is a control word
    logic tx_word_eop; // Control word closes a packet
    logic [WORD_W-1:0] tx_word_data; // Word contents
    logic tx_reset_req; // Synchronous transmit-side reset
    // ****************************************
    // Framer to user
    // ****************************************
    logic tx_word_ready; // Framer takes words
    logic tx_underflow_err; // Link starved mid packet
    logic tx_burst_err; // Short burst without end of packet
    logic tx_overflow_err; // Critical internal failure
    logic [LANES-1:0] rx_lane_status; // Latest diagnostic lane bit
    logic [LANES-1:0] rx_intf_status; // Latest diagnostic interface bit
    logic [LANES-1:0] rx_diag_check_good; // Latest diagnostic check good

    modport framer (
        input tx_calendar_xon_bits, tx_min_burst_length, tx_word_valid, tx_word_ctrl,
        input tx_word_eop, tx_word_data, tx_reset_req,
        output tx_word_ready, tx_underflow_err, tx_burst_err, tx_overflow_err,
        output rx_lane_status, rx_intf_status, rx_diag_check_good
    );
    modport user (
        output tx_calendar_xon_bits, tx_min_burst_length, tx_word_valid, tx_word_ctrl,
        output tx_word_eop, tx_word_data, tx_reset_req,
        input tx_word_ready, tx_underflow_err, tx_burst_err, tx_overflow_err,
        input rx_lane_status, rx_intf_status, rx_diag_check_good
    );
endinterface : ifc_link_if
`default_nettype wire

// ==== design/ifc_framer.sv ====
// Framer end: calendar insertion into control words, transmit errors, lane status
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module ifc_framer #(
    parameter int N_LANES = ifc_pkg::LANES, // Receive lanes
    parameter int N_ENTRIES = ifc_pkg::CAL_ENTRIES // Calendar length
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    ifc_link_if.framer lnk,
    input wire logic [N_LANES-1:0] rx_diag_strobe,
    input wire logic [N_LANES-1:0][ifc_pkg::WORD_W-1:0] rx_diag_word,
    input wire logic [N_LANES-1:0] rx_diag_crc_ok,
    output logic link_valid_ff,
    output logic link_ctrl_ff,
    output logic [ifc_pkg::WORD_W-1:0] link_word_ff
);
    import ifc_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Refused while elaborating, since the slicing assumes these sizes
    if (N_LANES != LANES || N_ENTRIES != CAL_ENTRIES) begin : g_bad_size
        $error("ifc_framer: lane or calendar size not supported");
    end

    // ****************************************
    // State
    // ****************************************
    logic [GRP_W-1:0] grp_ff; // Next calendar group to send
    logic [BURST_W-1:0] burst_cnt_ff; // Data words since last control word
    logic seen_ctrl_ff; // A control word opened the current burst
    logic in_pkt_ff; // Between start and end of a packet
    logic ready_ff; // Word acceptance
    logic underflow_ff;
    logic burst_err_ff;
    logic overflow_ff;
    logic [N_LANES-1:0] lane_stat_ff;
    logic [N_LANES-1:0] intf_stat_ff;
    logic [N_LANES-1:0] check_good_ff;
    logic take; // Word accepted this cycle
    logic short_burst; // Closing control word ends a short burst
    logic [CW_CAL_HI-CW_CAL_LO:0] cal_slice; // Group on the wire order
    logic [WORD_W-1:0] ctrl_word; // Outgoing control word

    assign take = lnk.tx_word_valid && ready_ff;

    // Burst below minimum, closed by a control word lacking EOP
    assign short_burst = take && lnk.tx_word_ctrl && seen_ctrl_ff && !lnk.tx_word_eop
        && (burst_cnt_ff < lnk.tx_min_burst_length);

    // ****************************************
    // Calendar slice selection
    // ****************************************
    // Entry k of the group lands on bit 55-k, so entry 0 is on top
    always_comb begin
        cal_slice = '0;
        for (int k = 0; k < CAL_GROUP; k++) begin
            // Set bit is XON, clear bit is XOFF; passed as is
            cal_slice[CAL_GROUP-1-k] = lnk.tx_calendar_xon_bits[grp_ff*CAL_GROUP+k];
        end
    end

    // Overwrite the calendar field and the start marker
    always_comb begin
        ctrl_word = lnk.tx_word_data;
        ctrl_word[CW_CAL_HI:CW_CAL_LO] = cal_slice;
        ctrl_word[CW_CAL_START] = (grp_ff == GRP_FIRST);
    end

    // ****************************************
    // Calendar group walk
    // ****************************************
    // Wraps after the last group so the calendar repeats
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            grp_ff <= GRP_FIRST;
        end else if (lnk.tx_reset_req) begin
            grp_ff <= GRP_FIRST;
        end else if (take && lnk.tx_word_ctrl) begin
            grp_ff <= grp_ff + 4'h1;
        end
    end

    // ****************************************
    // Link output register
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_valid_ff <= 1'b0;
            link_ctrl_ff <= 1'b0;
            link_word_ff <= WORD_ZERO;
        end else if (lnk.tx_reset_req) begin
            link_valid_ff <= 1'b0;
            link_ctrl_ff <= 1'b0;
            link_word_ff <= WORD_ZERO;
        end else begin
            link_valid_ff <= take;
            link_ctrl_ff <= take && lnk.tx_word_ctrl;
            // Data words pass untouched, control words get the calendar
            if (take) begin
                link_word_ff <= lnk.tx_word_ctrl ? ctrl_word : lnk.tx_word_data;
            end
        end
    end

    // ****************************************
    // Burst length tracking
    // ****************************************
    // Saturates so very long bursts never wrap into a false short one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_cnt_ff <= BURST_ZERO;
            seen_ctrl_ff <= 1'b0;
        end else if (lnk.tx_reset_req) begin
            burst_cnt_ff <= BURST_ZERO;
            seen_ctrl_ff <= 1'b0;
        end else if (take && lnk.tx_word_ctrl) begin
            burst_cnt_ff <= BURST_ZERO;
            seen_ctrl_ff <= 1'b1;
        end else if (take && burst_cnt_ff != BURST_MAX) begin
            burst_cnt_ff <= burst_cnt_ff + BURST_ONE;
        end
    end

    // ****************************************
    // Packet tracking for starvation
    // ****************************************
    // A control word without EOP opens a packet, one with EOP closes it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            in_pkt_ff <= 1'b0;
        end else if (lnk.tx_reset_req) begin
            in_pkt_ff <= 1'b0;
        end else if (take && lnk.tx_word_ctrl) begin
            in_pkt_ff <= !lnk.tx_word_eop;
        end
    end

    // ****************************************
    // Sticky transmit errors
    // ****************************************
    // Only the transmit reset clears them; the core cannot recover alone
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            underflow_ff <= 1'b0;
        end else if (in_pkt_ff && !lnk.tx_word_valid && ready_ff) begin
            underflow_ff <= 1'b1;
        end else if (lnk.tx_reset_req) begin
            underflow_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_err_ff <= 1'b0;
        end else if (short_burst) begin
            burst_err_ff <= 1'b1;
        end else if (lnk.tx_reset_req) begin
            burst_err_ff <= 1'b0;
        end
    end

    // A word offered while acceptance is withdrawn would be lost
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_ff <= 1'b0;
        end else if (lnk.tx_word_valid && !ready_ff && !lnk.tx_reset_req) begin
            overflow_ff <= 1'b1;
        end else if (lnk.tx_reset_req) begin
            overflow_ff <= 1'b0;
        end
    end

    // ****************************************
    // Acceptance
    // ****************************************
    // Stalls after a short burst or overflow until the user resets the transmit side
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= !lnk.tx_reset_req && !burst_err_ff && !short_burst && !overflow_ff;
        end
    end

    // ****************************************
    // Diagnostic word capture per lane
    // ****************************************
    // Values hold until the next diagnostic word on that lane
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lane_stat_ff <= '0;
            intf_stat_ff <= '0;
            check_good_ff <= '0;
        end else begin
            for (int i = 0; i < N_LANES; i++) begin
                if (rx_diag_strobe[i]) begin
                    lane_stat_ff[i] <= rx_diag_word[i][DW_LANE_STAT];
                    intf_stat_ff[i] <= rx_diag_word[i][DW_INTF_STAT];
                    check_good_ff[i] <= rx_diag_crc_ok[i];
                end
            end
        end
    end

    // ****************************************
    // Outputs to the user end
    // ****************************************
    assign lnk.tx_word_ready = ready_ff;
    assign lnk.tx_underflow_err = underflow_ff;
    assign lnk.tx_burst_err = burst_err_ff;
    assign lnk.tx_overflow_err = overflow_ff;
    assign lnk.rx_lane_status = lane_stat_ff;
    assign lnk.rx_intf_status = intf_stat_ff;
    assign lnk.rx_diag_check_good = check_good_ff;
endmodule : ifc_framer
`default_nettype wire

// ==== design/ifc_user.sv ====
// User end: drives the calendar and words, resets on faults, qualifies lane status
`timescale 1ns/1ps
`default_nettype none
module ifc_user #(
    parameter int N_LANES = ifc_pkg::LANES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    ifc_link_if.user lnk,
    input wire logic [ifc_pkg::CAL_ENTRIES-1:0] usr_xon_bits,
    input wire logic [ifc_pkg::BURST_W-1:0] usr_min_burst,
    input wire logic usr_valid,
    input wire logic usr_ctrl,
    input wire logic usr_eop,
    input wire logic [ifc_pkg::WORD_W-1:0] usr_data,
    output logic usr_ready_ff,
    output logic usr_fault_ff,
    output logic usr_underflow_ff,
    output logic [N_LANES-1:0] usr_lane_ok_ff,
    output logic [N_LANES-1:0] usr_intf_ok_ff
);
    import ifc_pkg::*;

    // Refused while elaborating, since the status masks assume this size
    if (N_LANES != LANES) begin : g_bad_size
        $error("ifc_user: lane count not supported");
    end

    // ****************************************
    // State
    // ****************************************
    logic [CAL_ENTRIES-1:0] cal_ff; // Registered calendar
    logic [BURST_W-1:0] min_ff;
    logic valid_ff;
    logic ctrl_ff;
    logic eop_ff;
    logic [WORD_W-1:0] data_ff;
    ifc_rec_t rec_ff;
    logic [3:0] rst_cnt_ff; // Reset pulse length
    logic rst_req_ff;

    // ****************************************
    // Calendar and configuration
    // ****************************************
    // Registered here so the framer sees it on the clock
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_ff <= {CAL_ENTRIES{XOFF}};
            min_ff <= MIN_BURST_RST;
        end else begin
            cal_ff <= usr_xon_bits;
            min_ff <= usr_min_burst;
        end
    end

    // ****************************************
    // Word forwarding
    // ****************************************
    // One register stage; the user offers only while ready was high the cycle before
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_ff <= 1'b0;
            ctrl_ff <= 1'b0;
            eop_ff <= 1'b0;
            data_ff <= WORD_ZERO;
            usr_ready_ff <= 1'b0;
        end else begin
            valid_ff <= usr_valid && usr_ready_ff && lnk.tx_word_ready && rec_ff == IFC_RUN;
            ctrl_ff <= usr_ctrl;
            eop_ff <= usr_eop;
            data_ff <= usr_data;
            usr_ready_ff <= lnk.tx_word_ready && rec_ff == IFC_RUN;
        end
    end

    // ****************************************
    // Fault recovery
    // ****************************************
    // Short burst or overflow forces a timed transmit reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rec_ff <= IFC_RUN;
            rst_cnt_ff <= 4'h0;
            rst_req_ff <= 1'b0;
        end else begin
            case (rec_ff)
                IFC_RUN: begin
                    if (lnk.tx_burst_err || lnk.tx_overflow_err) begin
                        rec_ff <= IFC_RESET;
                        rst_req_ff <= 1'b1;
                        rst_cnt_ff <= TX_RST_CYC_W;
                    end
                end
                IFC_RESET: begin
                    if (rst_cnt_ff <= 4'h1) begin
                        rec_ff <= IFC_WAIT;
                        rst_req_ff <= 1'b0;
                    end
                    rst_cnt_ff <= rst_cnt_ff - 4'h1;
                end
                IFC_WAIT: begin
                    rec_ff <= IFC_RUN;
                end
                default: begin
                    rec_ff <= IFC_RUN;
                    rst_req_ff <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Status reporting
    // ****************************************
    // Lane status is masked unless the diagnostic check was good
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            usr_fault_ff <= 1'b0;
            usr_underflow_ff <= 1'b0;
            usr_lane_ok_ff <= '0;
            usr_intf_ok_ff <= '0;
        end else begin
            usr_fault_ff <= rec_ff != IFC_RUN;
            usr_underflow_ff <= lnk.tx_underflow_err;
            usr_lane_ok_ff <= lnk.rx_lane_status & lnk.rx_diag_check_good;
            usr_intf_ok_ff <= lnk.rx_intf_status & lnk.rx_diag_check_good;
        end
    end

    assign lnk.tx_calendar_xon_bits = cal_ff;
    assign lnk.tx_min_burst_length = min_ff;
    assign lnk.tx_word_valid = valid_ff;
    assign lnk.tx_word_ctrl = ctrl_ff;
    assign lnk.tx_word_eop = eop_ff;
    assign lnk.tx_word_data = data_ff;
    assign lnk.tx_reset_req = rst_req_ff;
endmodule : ifc_user
`default_nettype wire

// ==== tb/ifc_assertions.sv ====
// Checker watching the link interface between the framer and user ends
`timescale 1ns/1ps
`default_nettype none
module ifc_assertions (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tx_word_valid,
    input wire logic tx_word_ctrl,
    input wire logic tx_word_eop,
    input wire logic tx_word_ready,
    input wire logic tx_reset_req,
    input wire logic tx_underflow_err,
    input wire logic tx_burst_err,
    input wire logic tx_overflow_err
);
    // ****************************************
    // Clocking and sequences
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Recovery: eight cycles of request, then released
    sequence s_recover;
        tx_reset_req [*8] ##1 !tx_reset_req;
    endsequence

    // Errors that send the user end into recovery
    sequence s_fault_rise;
        $rose(tx_burst_err || tx_overflow_err);
    endsequence

    // ****************************************
    // Properties
    // ****************************************
    a_burst_cause: assert property ($rose(tx_burst_err) |->
        $past(tx_word_valid && tx_word_ready && tx_word_ctrl && !tx_word_eop))
        else $error("short burst flag without an open control word");
    a_burst_sticky: assert property (tx_burst_err && !tx_reset_req |=> tx_burst_err)
        else $error("short burst flag dropped on its own");
    a_burst_stops_ready: assert property ($rose(tx_burst_err) |-> ##[0:1] !tx_word_ready)
        else $error("framer still ready after short burst");
    a_fault_recovery: assert property (s_fault_rise |=> s_recover)
        else $error("reset request not eight cycles long");
    a_req_clears_errs: assert property (tx_reset_req ##1 tx_reset_req |->
        !tx_burst_err && !tx_overflow_err && !tx_underflow_err)
        else $error("errors survive a reset request");
    a_ready_returns: assert property ($fell(tx_reset_req) |-> ##[0:1] tx_word_ready)
        else $error("ready not back after reset request");
    a_ovf_on_refuse: assert property (tx_word_valid && !tx_word_ready && !tx_reset_req
        |=> tx_overflow_err)
        else $error("refused word did not flag overflow");
    a_ovf_cause: assert property ($rose(tx_overflow_err) |->
        $past(tx_word_valid && !tx_word_ready && !tx_reset_req))
        else $error("overflow flag without a refused word");
    a_unf_cause: assert property ($rose(tx_underflow_err) |->
        $past(tx_word_ready && !tx_word_valid))
        else $error("underflow flag without a starved cycle");
    a_unf_sticky: assert property (tx_underflow_err && !tx_reset_req |=> tx_underflow_err)
        else $error("underflow flag dropped on its own");
endmodule : ifc_assertions
`default_nettype wire

// ==== tb/inband_flow_control_status_test.sv ====
// Testbench joining both ends through the link interface
`timescale 1ns/1ps
`default_nettype none
module inband_flow_control_status_test;
    import ifc_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [CAL_ENTRIES-1:0] cal; // Calendar pattern
    logic valid = 1'b0, ctrl = 1'b0, eop = 1'b0;
    logic [WORD_W-1:0] data = WORD_ZERO;
    logic [BURST_W-1:0] min_burst = MIN_BURST_RST; // Configured burst minimum
    logic [LANES-1:0] strobe = 12'h000, crc_ok = 12'h000;
    logic [LANES-1:0][WORD_W-1:0] dword;
    logic lv, lc, rdy, fault, unf;
    logic [WORD_W-1:0] lw;
    logic [LANES-1:0] lane_ok, intf_ok;
    logic [WORD_W:0] got_q[$]; // Captured {ctrl, word}
    int fail_count = 0, checked = 0;
    ifc_link_if lnk ();

    // ****************************************
    // Design and checker
    // ****************************************
    ifc_framer i_ifc_framer (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lnk),
        .rx_diag_strobe(strobe), .rx_diag_word(dword), .rx_diag_crc_ok(crc_ok),
        .link_valid_ff(lv), .link_ctrl_ff(lc), .link_word_ff(lw));
    ifc_user i_ifc_user (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lnk),
        .usr_xon_bits(cal), .usr_min_burst(min_burst), .usr_valid(valid),
        .usr_ctrl(ctrl), .usr_eop(eop), .usr_data(data), .usr_ready_ff(rdy),
        .usr_fault_ff(fault), .usr_underflow_ff(unf), .usr_lane_ok_ff(lane_ok),
        .usr_intf_ok_ff(intf_ok));
    ifc_assertions i_ifc_assertions (.ref_clk(ref_clk), .reset_n(reset_n),
        .tx_word_valid(lnk.tx_word_valid), .tx_word_ctrl(lnk.tx_word_ctrl),
        .tx_word_eop(lnk.tx_word_eop), .tx_word_ready(lnk.tx_word_ready),
        .tx_reset_req(lnk.tx_reset_req), .tx_underflow_err(lnk.tx_underflow_err),
        .tx_burst_err(lnk.tx_burst_err), .tx_overflow_err(lnk.tx_overflow_err));

    // 10 MHz clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Capture every word the framer puts on the link, clear of its launching edge
    always @(negedge ref_clk) begin
        if (lv === 1'b1) begin
            got_q.push_back({lc, lw});
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk_w(input logic [WORD_W-1:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, exp, input string msg);
        chk_w({63'h0, got}, {63'h0, exp}, msg);
    endtask : chk_b

    // Expected control word: data with group g of the calendar laid in
    function automatic logic [WORD_W-1:0] ctl_word(int g, logic [WORD_W-1:0] d);
        d[CW_CAL_START] = (g == 0);
        for (int k = 0; k < CAL_GROUP; k++) begin
            d[CW_CAL_HI-k] = cal[CAL_GROUP*g+k];
        end
        return d;
    endfunction : ctl_word

    // One word offered for one cycle; caller lowers valid later
    task automatic send(input logic c, e, input logic [WORD_W-1:0] d);
        valid = 1'b1;
        ctrl = c;
        eop = e;
        data = d;
        @(negedge ref_clk);
    endtask : send

    task automatic idle(input int n);
        valid = 1'b0;
        repeat (n) @(negedge ref_clk);
    endtask : idle

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Watchdog: the whole run needs well under 1000 cycles
    initial begin
        #400_000;
        fail_count++;
        give_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    logic [WORD_W-1:0] row_data[21], row_exp[21]; // Inputs beside expected words
    logic row_ctrl[21], row_eop[21];
    initial begin
        for (int i = 0; i < CAL_ENTRIES; i++) begin
            cal[i] = ((i % 7) + (i / 16)) % 3 == 0; // Differs from group to group
        end
        for (int l = 0; l < LANES; l++) begin
            dword[l] = WORD_ZERO;
        end
        // Rows: 17 closed control words (wrap), two data words, then a packet
        for (int i = 0; i < 21; i++) begin
            row_data[i] = 64'h8100_0000_0000_00A0 + 64'(i);
            row_ctrl[i] = (i < 17) || (i > 18);
            row_eop[i] = (i != 19);
            row_exp[i] = row_ctrl[i] ? ctl_word(i < 17 ? i % 16 : i - 18, row_data[i])
                                     : row_data[i];
        end
        // Reset values while held
        repeat (20) @(negedge ref_clk);
        chk_w(64'(lnk.tx_min_burst_length), 64'(MIN_BURST_RST), "min burst at reset");
        chk_b(lnk.tx_burst_err | lnk.tx_underflow_err | lnk.tx_overflow_err, 1'b0,
            "errors at reset");
        reset_n = 1'b1;
        idle(3);
        chk_b(rdy, 1'b1, "user ready");
        // Ordinary traffic, back to back
        for (int i = 0; i < 21; i++) begin
            send(row_ctrl[i], row_eop[i], row_data[i]);
        end
        idle(5);
        chk_w(64'(got_q.size()), 64'd21, "word count");
        for (int i = 0; i < 21; i++) begin
            chk_b(got_q[i][WORD_W], row_ctrl[i], "ctrl flag");
            chk_w(got_q[i][WORD_W-1:0], row_exp[i], "link word");
        end
        chk_b(lnk.tx_burst_err | lnk.tx_underflow_err, 1'b0, "clean traffic");
        $display("Test calendar rows done");
        // Short burst closed with end of packet is not an error
        send(1'b1, 1'b1, WORD_ZERO);
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b1, 1'b1, WORD_ZERO);
        idle(4);
        chk_b(lnk.tx_burst_err, 1'b0, "short burst with end");
        // Full burst, gap inside the packet, short burst without end, then a lost word
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b1, 1'b0, WORD_ZERO);
        idle(4);
        chk_b(lnk.tx_underflow_err, 1'b1, "gap in packet");
        chk_b(unf, 1'b1, "user sees gap");
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b1, 1'b0, WORD_ZERO);
        send(1'b0, 1'b0, WORD_ZERO); // Offered just as ready drops
        idle(1);
        chk_b(lnk.tx_burst_err, 1'b1, "short burst");
        chk_b(lnk.tx_overflow_err, 1'b1, "refused word");
        idle(14);
        chk_b(lnk.tx_burst_err | lnk.tx_underflow_err, 1'b0, "after recovery");
        chk_b(fault, 1'b0, "recovery over");
        got_q.delete();
        send(1'b1, 1'b1, 64'h0000_0000_0000_0055);
        idle(4);
        chk_w(got_q[0][WORD_W-1:0], ctl_word(0, 64'h0000_0000_0000_0055),
            "group restarts");
        // A one-word burst is legal once the minimum is lowered to one
        min_burst = BURST_ONE;
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b1, 1'b0, WORD_ZERO);
        send(1'b0, 1'b0, WORD_ZERO);
        send(1'b1, 1'b1, WORD_ZERO);
        idle(4);
        chk_b(lnk.tx_burst_err | lnk.tx_underflow_err, 1'b0, "lowered minimum");
        $display("Test burst and recovery done");
        // Diagnostic status per lane, twice so the latest value wins
        for (int pass = 0; pass < 2; pass++) begin
            for (int l = 0; l < LANES; l++) begin
                dword[l] = WORD_ZERO;
                dword[l][DW_LANE_STAT] = (l % 2) ^ pass[0];
                dword[l][DW_INTF_STAT] = (l % 3 == 0) ^ pass[0];
            end
            crc_ok = pass[0] ? 12'h0F0F : 12'h0FF3;
            strobe = 12'hFFF;
            idle(1);
            strobe = 12'h000;
            idle(2);
            for (int l = 0; l < LANES; l++) begin
                chk_b(lnk.rx_lane_status[l], dword[l][DW_LANE_STAT], "lane bit");
                chk_b(lnk.rx_intf_status[l], dword[l][DW_INTF_STAT], "intf bit");
                chk_b(lnk.rx_diag_check_good[l], crc_ok[l], "check good");
                chk_b(lane_ok[l], dword[l][DW_LANE_STAT] & crc_ok[l], "lane ok");
                chk_b(intf_ok[l], dword[l][DW_INTF_STAT] & crc_ok[l], "intf ok");
            end
        end
        $display("Test lane status done");
        give_verdict();
    end
endmodule : inband_flow_control_status_test
`default_nettype wire
